// file: legacy_bios_region_steering.sv
// Attribute register bank and read/write steering for 0C0000h-0EFFFFh
`timescale 1ns/1ns
module legacy_bios_region_steering #(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Configuration space byte access
	input wire legacy_steer_pkg::cfg_t i_cfg,
	output logic [7:0] o_cfg_rdata,
	output logic o_cfg_rvalid,
	// Legacy memory cycles in
	input wire legacy_steer_pkg::req_t i_req,
	// Routing decision out
	output legacy_steer_pkg::route_t o_route
);

	// ---------------------------------------------
	// Elaboration checks
	// ---------------------------------------------
	if (ADDR_W != 32) begin : g_bad_width
		$error("ADDR_W must be 32");
	end

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	legacy_steer_pkg::state_t state_reg;
	legacy_steer_pkg::state_t state_next;
	logic [5:0] seg_idx;
	logic in_legacy;
	logic [2:0] reg_idx;
	logic [1:0] field;
	logic [2:0] cfg_idx;
	logic cfg_hit;

	// Map a configuration offset onto a register slot
	always_comb begin
		cfg_hit = 1'b1;
		cfg_idx = 3'h0;
		case (i_cfg.addr)
			legacy_steer_pkg::BIOS_SEG_C0_C7_ATTR: cfg_idx = 3'h0;
			legacy_steer_pkg::BIOS_SEG_C8_CF_ATTR: cfg_idx = 3'h1;
			legacy_steer_pkg::BIOS_SEG_D0_D7_ATTR: cfg_idx = 3'h2;
			legacy_steer_pkg::BIOS_SEG_D8_DF_ATTR: cfg_idx = 3'h3;
			legacy_steer_pkg::BIOS_SEG_E0_E7_ATTR: cfg_idx = 3'h4;
			legacy_steer_pkg::BIOS_SEG_E8_EF_ATTR: cfg_idx = 3'h5;
			default: cfg_hit = 1'b0;
		endcase
	end

	// Segment decode: 16 KB slices, two per register, upper field odd
	always_comb begin
		seg_idx = i_req.addr[legacy_steer_pkg::SEG_LSB +: 6];
		in_legacy = (i_req.addr[31:20] == 12'h000) &&
			(seg_idx >= legacy_steer_pkg::SEG_FIRST) &&
			(seg_idx <= legacy_steer_pkg::SEG_LAST); // R08
		reg_idx = 3'((seg_idx - legacy_steer_pkg::SEG_FIRST) >> 1); // R05
		if (!in_legacy) begin
			reg_idx = 3'h0;
		end
		if (seg_idx[0]) begin
			field = state_reg.attr[reg_idx]
				[legacy_steer_pkg::UPPER_LSB +: 2]; // R06 R08 R10 R12 R14 R16
		end else begin
			field = state_reg.attr[reg_idx]
				[legacy_steer_pkg::LOWER_LSB +: 2]; // R07 R09 R11 R13 R15 R17
		end
	end

	// Next state: register writes, read data and routing
	always_comb begin
		state_next = state_reg;
		state_next.rvalid = i_cfg.rd;
		if (i_cfg.rd) begin
			state_next.rdata = cfg_hit ? (state_reg.attr[cfg_idx] &
				legacy_steer_pkg::ATTR_WMASK) : 8'h00; // R20
		end
		if (i_cfg.wr && cfg_hit) begin
			state_next.attr[cfg_idx] = i_cfg.wdata &
				legacy_steer_pkg::ATTR_WMASK; // R20
		end
		// Same decision whoever started the cycle
		state_next.route.valid = i_req.valid;
		state_next.route.write = i_req.write;
		state_next.route.from_io = i_req.from_io; // R19
		state_next.route.claim = i_req.valid && in_legacy;
		state_next.route.to_mem = 1'b0;
		state_next.route.to_south = 1'b0;
		if (i_req.valid && in_legacy) begin
			case (legacy_steer_pkg::steer_t'(field))
				legacy_steer_pkg::STEER_DISABLED: begin
					state_next.route.to_south = 1'b1; // R01
				end
				legacy_steer_pkg::STEER_READ_ONLY: begin
					state_next.route.to_mem = !i_req.write; // R02
					state_next.route.to_south = i_req.write; // R02
				end
				legacy_steer_pkg::STEER_WRITE_ONLY: begin
					state_next.route.to_mem = i_req.write; // R03
					state_next.route.to_south = !i_req.write; // R03
				end
				legacy_steer_pkg::STEER_NORMAL: begin
					state_next.route.to_mem = 1'b1; // R04
				end
				default: begin
					state_next.route.to_south = 1'b1;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= '0;
			state_reg.attr <= {legacy_steer_pkg::ATTR_REGS{
				legacy_steer_pkg::ATTR_RESET}};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flops
	assign o_cfg_rdata = state_reg.rdata;
	assign o_cfg_rvalid = state_reg.rvalid;
	assign o_route = state_reg.route;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	// Expected memory routing for a field and direction
	function automatic logic mem_of(input logic [1:0] f, input logic wr);
		mem_of = f[wr];
	endfunction

	// Address inside an inclusive range
	function automatic logic in_rng(input logic [31:0] a,
		input logic [31:0] lo, input logic [31:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	AST_DISABLED: assert property ( // R01
		@(posedge i_ref_clk) disable iff (i_reset)
		o_route.claim && (mem_of(2'h0, o_route.write) == 1'b0) &&
		$past(field) == 2'h0 |-> o_route.to_south && !o_route.to_mem)
		else $error("disabled segment not sent south");

	AST_READ_ONLY: assert property ( // R02
		@(posedge i_ref_clk) disable iff (i_reset)
		o_route.claim && $past(field) == 2'h1 |->
		o_route.to_mem == !o_route.write &&
		o_route.to_south == o_route.write)
		else $error("read-only segment misrouted");

	AST_WRITE_ONLY: assert property ( // R03
		@(posedge i_ref_clk) disable iff (i_reset)
		o_route.claim && $past(field) == 2'h2 |->
		o_route.to_mem == o_route.write &&
		o_route.to_south == !o_route.write)
		else $error("write-only segment misrouted");

	AST_NORMAL: assert property ( // R04
		@(posedge i_ref_clk) disable iff (i_reset)
		o_route.claim && $past(field) == 2'h3 |->
		o_route.to_mem && !o_route.to_south)
		else $error("normal segment not in memory");

	AST_ONE_TARGET: assert property ( // R05
		@(posedge i_ref_clk) disable iff (i_reset)
		o_route.claim |-> (o_route.to_mem ^ o_route.to_south))
		else $error("claimed cycle has no single target");

	AST_SEG_C4: assert property ( // R06
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000C4000, 32'h000C7FFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[0][5:4]),
		$past(i_req.write)))
		else $error("0C4000 segment not steered by first upper field");

	AST_SEG_C0: assert property ( // R07
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000C0000, 32'h000C3FFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[0][1:0]),
		$past(i_req.write)))
		else $error("0C0000 segment not steered by first lower field");

	AST_SEG_CC: assert property ( // R08
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000CC000, 32'h000CFFFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[1][5:4]),
		$past(i_req.write)))
		else $error("0CC000 segment not steered by second upper field");

	AST_SEG_C8: assert property ( // R09
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000C8000, 32'h000CBFFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[1][1:0]),
		$past(i_req.write)))
		else $error("0C8000 segment not steered by second lower field");

	AST_SEG_D4: assert property ( // R10
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000D4000, 32'h000D7FFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[2][5:4]),
		$past(i_req.write)))
		else $error("0D4000 segment not steered by third upper field");

	AST_SEG_D0: assert property ( // R11
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000D0000, 32'h000D3FFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[2][1:0]),
		$past(i_req.write)))
		else $error("0D0000 segment not steered by third lower field");

	AST_SEG_DC: assert property ( // R12
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000DC000, 32'h000DFFFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[3][5:4]),
		$past(i_req.write)))
		else $error("0DC000 segment not steered by fourth upper field");

	AST_SEG_D8: assert property ( // R13
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000D8000, 32'h000DBFFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[3][1:0]),
		$past(i_req.write)))
		else $error("0D8000 segment not steered by fourth lower field");

	AST_SEG_E4: assert property ( // R14
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000E4000, 32'h000E7FFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[4][5:4]),
		$past(i_req.write)))
		else $error("0E4000 segment not steered by fifth upper field");

	AST_SEG_E0: assert property ( // R15
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000E0000, 32'h000E3FFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[4][1:0]),
		$past(i_req.write)))
		else $error("0E0000 segment not steered by fifth lower field");

	AST_SEG_EC: assert property ( // R16
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000EC000, 32'h000EFFFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[5][5:4]),
		$past(i_req.write)))
		else $error("0EC000 segment not steered by sixth upper field");

	AST_SEG_E8: assert property ( // R17
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000E8000, 32'h000EBFFF)
		|=> o_route.to_mem == mem_of($past(state_reg.attr[5][1:0]),
		$past(i_req.write)))
		else $error("0E8000 segment not steered by sixth lower field");

	AST_IO_SAME: assert property ( // R19
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_legacy |=>
		o_route.claim && o_route.from_io == $past(i_req.from_io) &&
		o_route.to_mem == mem_of($past(field), $past(i_req.write)))
		else $error("requester origin changed the steering");

	AST_RSVD_ZERO: assert property ( // R20
		@(posedge i_ref_clk) disable iff (i_reset)
		o_cfg_rvalid |-> (o_cfg_rdata & 8'hCC) == 8'h00)
		else $error("reserved attribute bits read non-zero");

	AST_WRITE_BACK: assert property ( // R20
		@(posedge i_ref_clk) disable iff (i_reset)
		i_cfg.wr && cfg_hit ##1 i_cfg.rd && !i_cfg.wr &&
		i_cfg.addr == $past(i_cfg.addr) |=>
		o_cfg_rdata == ($past(i_cfg.wdata, 2) & 8'h33))
		else $error("attribute write not read back");

	AST_OUTSIDE: assert property ( // R08
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && !in_rng(i_req.addr, 32'h000C0000, 32'h000EFFFF)
		|=> !o_route.claim && !o_route.to_mem && !o_route.to_south)
		else $error("cycle outside legacy area was claimed");

	// ---------------------------------------------
	// Register access and request echo checks
	// ---------------------------------------------
	// Read answer stands exactly one cycle after each read
	AST_RVALID_PULSE: assert property ( // R05
		@(posedge i_ref_clk) disable iff (i_reset)
		i_cfg.rd |=> o_cfg_rvalid)
		else $error("read answer missing after a read");

	AST_RVALID_IDLE: assert property ( // R05
		@(posedge i_ref_clk) disable iff (i_reset)
		!i_cfg.rd |=> !o_cfg_rvalid)
		else $error("read answer without a read");

	AST_RDATA_HOLD: assert property ( // R05
		@(posedge i_ref_clk) disable iff (i_reset)
		!i_cfg.rd |=> $stable(o_cfg_rdata))
		else $error("read data moved without a read");

	AST_UNMAPPED_ZERO: assert property ( // R20
		@(posedge i_ref_clk) disable iff (i_reset)
		i_cfg.rd && !cfg_hit |=> o_cfg_rdata == 8'h00)
		else $error("unmapped offset read non-zero");

	// Writes land at the next edge, masked; unmapped writes do nothing
	AST_WRITE_LANDS: assert property ( // R05
		@(posedge i_ref_clk) disable iff (i_reset)
		i_cfg.wr && cfg_hit |=> state_reg.attr[$past(cfg_idx)] ==
		($past(i_cfg.wdata) & 8'h33))
		else $error("attribute write did not land");

	AST_UNMAPPED_KEEP: assert property ( // R20
		@(posedge i_ref_clk) disable iff (i_reset)
		i_cfg.wr && !cfg_hit |=> state_reg.attr == $past(state_reg.attr))
		else $error("unmapped write changed an attribute");

	AST_RSVD_STORED: assert property ( // R20
		@(posedge i_ref_clk) disable iff (i_reset)
		(state_reg.attr & {6{8'hCC}}) == '0)
		else $error("reserved attribute bits stored");

	// One route per request, echoing direction and origin
	AST_ROUTE_VALID: assert property ( // R19
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid |=> o_route.valid &&
		o_route.write == $past(i_req.write) &&
		o_route.from_io == $past(i_req.from_io))
		else $error("request not echoed in its route");

	AST_ROUTE_IDLE: assert property ( // R19
		@(posedge i_ref_clk) disable iff (i_reset)
		!i_req.valid |=> !o_route.valid)
		else $error("route without a request");

	AST_CLAIM_RANGE: assert property ( // R05
		@(posedge i_ref_clk) disable iff (i_reset)
		i_req.valid && in_rng(i_req.addr, 32'h000C0000, 32'h000EFFFF)
		|=> o_route.claim)
		else $error("legacy cycle not claimed");

	AST_CLAIM_VALID: assert property ( // R05
		@(posedge i_ref_clk) disable iff (i_reset)
		o_route.claim |-> o_route.valid)
		else $error("claim without a valid route");

	AST_NO_TARGET: assert property ( // R05
		@(posedge i_ref_clk) disable iff (i_reset)
		!o_route.claim |-> !o_route.to_mem && !o_route.to_south)
		else $error("unclaimed cycle given a target");

endmodule : legacy_bios_region_steering

// file: legacy_steer_pkg.sv
// Constants, types and register map of the legacy BIOS region steering bank
//
// What this block does
// [R01] Field 00: every read and write of the segment goes to south link.
// [R02] Field 01: reads from main memory, writes forwarded to south link.
// [R03] Field 10: writes to main memory, reads forwarded to south link.
// [R04] Field 11: reads and writes both serviced by main memory.
// [R05] Each attribute register holds two independent per-segment steer fields.
// [R06] First register bits 5:4 steer 0C4000 to 0C7FFF.
// [R07] First register bits 1:0 steer 0C0000 to 0C3FFF.
// [R08] Second register covers 0C8000-0CFFFF; upper field steers 0CC000-0CFFFF.
// [R09] Second register lower field steers 0C8000 to 0CBFFF.
// [R10] Third register upper field steers 0D4000 to 0D7FFF.
// [R11] Third register lower field steers 0D0000 to 0D3FFF.
// [R12] Fourth register upper field steers 0DC000 to 0DFFFF.
// [R13] Fourth register lower field steers 0D8000 to 0DBFFF.
// [R14] Fifth register upper field steers 0E4000 to 0E7FFF.
// [R15] Fifth register lower field steers 0E0000 to 0E3FFF.
// [R16] Sixth register upper field steers 0EC000 to 0EFFFF.
// [R17] Sixth register lower field steers 0E8000 to 0EBFFF.
// [R18] Software keeps segments read-write whenever I/O cycles may reach them.
// [R19] Steering applies equally to processor and I/O requester cycles.
// [R20] Reserved bits 7:6 and 3:2 read zero; writes to them ignored.
package legacy_steer_pkg;

	// ---------------------------------------------
	// Configuration offsets of the attribute bytes
	// ---------------------------------------------
	localparam logic [7:0] BIOS_SEG_C0_C7_ATTR = 8'h91;
	localparam logic [7:0] BIOS_SEG_C8_CF_ATTR = 8'h92;
	localparam logic [7:0] BIOS_SEG_D0_D7_ATTR = 8'h93;
	localparam logic [7:0] BIOS_SEG_D8_DF_ATTR = 8'h94;
	localparam logic [7:0] BIOS_SEG_E0_E7_ATTR = 8'h95;
	localparam logic [7:0] BIOS_SEG_E8_EF_ATTR = 8'h96;
	localparam int ATTR_REGS = 6;
	localparam logic [7:0] ATTR_RESET = 8'h00;
	localparam logic [7:0] ATTR_WMASK = 8'h33;

	// ---------------------------------------------
	// Field positions and segment decode
	// ---------------------------------------------
	localparam int UPPER_LSB = 4;
	localparam int LOWER_LSB = 0;
	localparam int SEG_LSB = 14;
	localparam logic [5:0] SEG_FIRST = 6'h30;
	localparam logic [5:0] SEG_LAST = 6'h3B;

	// Steering field encodings
	typedef enum logic [1:0] {
		STEER_DISABLED = 2'h0,
		STEER_READ_ONLY = 2'h1,
		STEER_WRITE_ONLY = 2'h2,
		STEER_NORMAL = 2'h3
	} steer_t;

	// Configuration byte access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cfg_t;

	// Legacy memory cycle from a requester
	typedef struct packed {
		logic valid;
		logic write;
		logic from_io;
		logic [31:0] addr;
	} req_t;

	// Routing decision for one cycle
	typedef struct packed {
		logic valid;
		logic claim;
		logic to_mem;
		logic to_south;
		logic write;
		logic from_io;
	} route_t;

	// Whole state of the bank
	typedef struct packed {
		logic [ATTR_REGS-1:0][7:0] attr;
		logic [7:0] rdata;
		logic rvalid;
		route_t route;
	} state_t;

endpackage : legacy_steer_pkg

// file: legacy_requester_model.sv
// Requester model issuing legacy memory cycles, one per clock
`timescale 1ns/1ns
module legacy_requester_model (
	// Clock
	input wire logic i_ref_clk,
	// Cycle toward the bank
	output legacy_steer_pkg::req_t o_req
);

	// Idle from time zero
	initial o_req = '0;

	// One cycle per call; I/O cycles only reach read-write segments
	task automatic issue(input logic wr, input logic io, input logic rw_ok,
		input logic [31:0] addr);
		@(posedge i_ref_clk);
		#1;
		o_req <= '{valid: 1'b1, write: wr, from_io: io & rw_ok, addr: addr};
	endtask : issue

	// Release the request
	task automatic idle();
		@(posedge i_ref_clk);
		#1;
		o_req <= '0;
	endtask : idle

endmodule : legacy_requester_model

// file: legacy_bios_region_steering_test.sv
// Self-checking bench of the legacy BIOS region steering bank
`timescale 1ns/1ns
module legacy_bios_region_steering_test;

	// ----------------------------------------
	// Signals and bookkeeping
	// ----------------------------------------
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	legacy_steer_pkg::cfg_t i_cfg = '0;
	legacy_steer_pkg::req_t req;
	legacy_steer_pkg::route_t o_route;
	logic [7:0] o_cfg_rdata;
	logic o_cfg_rvalid;
	logic [7:0] shadow [6] = '{default: 8'h00};
	logic [7:0] rd_q [$];
	legacy_steer_pkg::route_t rt_q [$];
	logic [15:0] rnd = 16'hDB99;
	int fail_count = 0;
	int total_checks = 0;

	// 20 MHz clock
	always #25 i_ref_clk = ~i_ref_clk;

	legacy_bios_region_steering #(.ADDR_W(32)) uut (.i_ref_clk(i_ref_clk),
		.i_reset(i_reset), .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata),
		.o_cfg_rvalid(o_cfg_rvalid), .i_req(req), .o_route(o_route));
	legacy_requester_model model (.i_ref_clk(i_ref_clk), .o_req(req));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] step(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : step

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Config access; notes the expected read and the new shadow value
	task automatic cfg(input logic wr, input logic rd, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge i_ref_clk);
		#1;
		i_cfg <= '{wr: wr, rd: rd, addr: a, wdata: d};
		if (rd) rd_q.push_back(a >= 8'h91 && a <= 8'h96 ? shadow[a - 8'h91] : 8'h00);
		if (wr && a >= 8'h91 && a <= 8'h96) shadow[a - 8'h91] = d & 8'h33;
	endtask : cfg

	// Legacy cycle with its expected routing
	task automatic send(input logic wr, input logic io, input logic [31:0] a);
		logic [5:0] s;
		logic [1:0] f;
		logic ok;
		legacy_steer_pkg::route_t e;
		s = 6'((a - 32'hC0000) >> 14);
		f = s[0] ? shadow[s >> 1][5:4] : shadow[s >> 1][1:0];
		e = '0;
		e.valid = 1'b1;
		e.write = wr;
		e.claim = a >= 32'hC0000 && a <= 32'hEFFFF;
		ok = e.claim && f == 2'h3;
		e.from_io = io & ok;
		e.to_mem = e.claim & (wr ? f[1] : f[0]);
		e.to_south = e.claim & ~e.to_mem;
		rt_q.push_back(e);
		model.issue(wr, io, ok, a);
	endtask : send

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// Watcher: compare each result with the oldest note
	always @(negedge i_ref_clk) begin
		if (o_cfg_rvalid === 1'b1)
			check(o_cfg_rdata,
				rd_q.size() ? rd_q.pop_front() : 8'hXX);
		if (o_route.valid === 1'b1)
			check({2'h0, o_route},
				rt_q.size() ? {2'h0, rt_q.pop_front()} : 8'hXX);
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge i_ref_clk);
		#1;
		i_reset = 1'b0;
		// Reset values, unmapped offsets on both sides
		for (int a = 8'h90; a <= 8'h97; a++)
			cfg(1'b0, 1'b1, 8'(a), 8'h00);
		$display("test reset values done");
		// Write and read in one cycle, then read back
		for (int a = 8'h90; a <= 8'h97; a++) begin
			rnd = step(rnd);
			cfg(1'b1, 1'b1, 8'(a), rnd[7:0]);
		end
		// Write then read the same byte on the next cycle
		cfg(1'b1, 1'b0, 8'h93, rnd[15:8]);
		cfg(1'b0, 1'b1, 8'h93, 8'h00);
		for (int a = 8'h90; a <= 8'h97; a++)
			cfg(1'b0, 1'b1, 8'(a), 8'h00);
		$display("test register access done");
		// Every code in every field, then random mixes
		for (int r = 0; r < 12; r++) begin
			for (int a = 0; a < 6; a++) begin
				rnd = step(rnd);
				cfg(1'b1, 1'b0, 8'h91 + 8'(a),
					r < 4 ? 8'(r * 8'h11) : rnd[7:0]);
			end
			cfg(1'b0, 1'b0, 8'h00, 8'h00);
			for (int s = 0; s < 24; s++) begin
				rnd = step(rnd);
				send(s[0], rnd[0], 32'hC0000 + 32'(s >> 1) * 32'h4000
					+ (rnd[1] ? 32'h3FFF : 32'(rnd[15:2])));
			end
			// Release the requester before the next reprogramming
			model.idle();
		end
		// Reset in mid-run returns every field to disabled
		@(posedge i_ref_clk);
		#1;
		i_reset = 1'b1;
		shadow = '{default: 8'h00};
		repeat (2) @(posedge i_ref_clk);
		#1;
		i_reset = 1'b0;
		for (int a = 8'h91; a <= 8'h96; a++)
			cfg(1'b0, 1'b1, 8'(a), 8'h00);
		cfg(1'b0, 1'b0, 8'h00, 8'h00);
		send(1'b1, 1'b1, 32'hD4000);
		send(1'b0, 1'b0, 32'hEFFFF);
		model.idle();
		$display("test mid-run reset done");
		// Just outside the region and a high address bit
		send(1'b0, 1'b0, 32'hBFFFF);
		send(1'b1, 1'b0, 32'hF0000);
		send(1'b0, 1'b1, 32'h800C0000);
		model.idle();
		$display("test steering done");
		for (int n = 0; n < 20 && (rd_q.size() || rt_q.size()); n++)
			@(posedge i_ref_clk);
		if (rd_q.size() || rt_q.size())
			fail_count++;
		end_of_test();
	end

endmodule : legacy_bios_region_steering_test
